// file: tcs_pkg.sv
// package: offsets, field positions, delivery values and command codes of the system area
package tcs_pkg;
  // byte addresses of the system area, reached with system_area_select high
  localparam logic [15:0] TCS_HOST_PASSWORD_OFS = 16'h0900;
  localparam logic [15:0] TCS_RADIO_PW1_OFS     = 16'h0904;
  localparam logic [15:0] TCS_RADIO_PW2_OFS     = 16'h0908;
  localparam logic [15:0] TCS_RADIO_PW3_OFS     = 16'h090C;
  localparam logic [15:0] TCS_NV_CONFIG_OFS     = 16'h0910;
  localparam logic [15:0] TCS_REVISION_OFS      = 16'h0911;
  localparam logic [15:0] TCS_FAMILY_ID_OFS     = 16'h0912;
  localparam logic [15:0] TCS_FORMAT_ID_OFS     = 16'h0913;
  localparam logic [15:0] TCS_UNIQUE_ID_OFS     = 16'h0914;
  localparam logic [15:0] TCS_IDENT_SIZE_OFS    = 16'h091C;
  localparam logic [15:0] TCS_VOL_CTRL_OFS      = 16'h0920;
  // configuration byte fields
  localparam int TCS_CFG_SINK_LO_BIT = 0;
  localparam int TCS_CFG_SINK_HI_BIT = 1;
  localparam int TCS_CFG_HDEF_BIT    = 2;
  localparam int TCS_CFG_PIN_BIT     = 3;
  // control register fields
  localparam int TCS_CTL_HON_BIT     = 0;
  localparam int TCS_CTL_FIELD_BIT   = 1;
  localparam int TCS_CTL_WDONE_BIT   = 7;
  // delivery values
  localparam logic [31:0] TCS_PASSWORD_RST  = 32'h0000_0000;
  localparam logic [7:0]  TCS_NV_CONFIG_RST = 8'hF4;
  localparam logic [7:0]  TCS_FAMILY_RST    = 8'h00;
  localparam logic [7:0]  TCS_FORMAT_RST    = 8'hFF;
  // radio command selector
  typedef enum logic [2:0]
  {
    TCS_RCMD_NONE        = 3'h0,
    TCS_RCMD_CFG_READ    = 3'h1,
    TCS_RCMD_HCFG_WRITE  = 3'h2,
    TCS_RCMD_PCFG_WRITE  = 3'h3,
    TCS_RCMD_CTRL_READ   = 3'h4,
    TCS_RCMD_HON_WRITE   = 3'h5
  } tcs_rcmd_t;
endpackage : tcs_pkg

// file: tcs_system_area.sv
// system area: passwords, configuration byte, control register, identity bytes
`timescale 1ns/1ps
module tcs_system_area
  import tcs_pkg::*;
#(
  parameter logic [3:0]  REVISION    = 4'h1,                  // arbitrary value
  parameter logic [63:0] UNIQUE_ID   = 64'h0123_4567_89AB_CDEF, // arbitrary value
  parameter logic [31:0] IDENT_SIZE  = 32'h0011_2233          // arbitrary value
)
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  // host side byte port, one access per strobe
  input  wire logic        host_stb,
  input  wire logic        host_we,
  input  wire logic        system_area_select,
  input  wire logic [15:0] host_addr,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata,
  output logic             host_ack,
  // host password presentation
  input  wire logic        pw_present_stb,
  input  wire logic [31:0] pw_present_val,
  output logic             host_unlocked,
  // non-volatile write cycle progress
  input  wire logic        nv_write_start,
  input  wire logic        nv_write_done_ok,
  // radio command port
  input  wire logic        radio_stb,
  input  wire logic [2:0]  radio_cmd,
  input  wire logic [7:0]  radio_wdata,
  output logic      [7:0]  radio_rdata,
  // radio activity status
  input  wire logic        radio_busy,
  input  wire logic        radio_write_busy,
  input  wire logic        field_power_ok,
  input  wire logic        harvest_conditions_ok,
  // outputs
  output logic             radio_activity_pin_o,
  output logic             radio_activity_pin_oe,
  output logic             harvest_out_en,
  output logic      [1:0]  sink_range
);

  logic [31:0] host_password_ff;
  logic [31:0] nxt_host_password;
  logic [95:0] radio_pw_ff;
  logic [7:0]  cfg_ff;
  logic [7:0]  nxt_cfg;
  logic        harvest_on_ff;
  logic        nxt_harvest_on;
  logic        wdone_ff;
  logic        nxt_wdone;
  logic        unlocked_ff;
  logic        nxt_unlocked;
  logic        field_ff;
  logic        init_ff;
  logic [7:0]  host_rdata_ff;
  logic [7:0]  nxt_host_rdata;
  logic [7:0]  radio_rdata_ff;
  logic [7:0]  nxt_radio_rdata;
  logic        ack_ff;

  // byte view of a word by address low bits, little-end first
  function automatic logic [7:0] tcs_byte_sel(input logic [31:0] w, input logic [1:0] i);
    tcs_byte_sel = w[8*i +: 8];
  endfunction : tcs_byte_sel

  // address decode, host side
  wire host_acc   = host_stb & system_area_select;
  wire host_wr    = host_acc & host_we;
  wire hit_pw     = (host_addr[15:2] == TCS_HOST_PASSWORD_OFS[15:2]);
  wire hit_rpw    = (host_addr >= TCS_RADIO_PW1_OFS) && (host_addr < TCS_NV_CONFIG_OFS);
  wire hit_cfg    = (host_addr == TCS_NV_CONFIG_OFS);
  wire hit_ctl    = (host_addr == TCS_VOL_CTRL_OFS);
  wire [15:0] uid_off   = host_addr - TCS_UNIQUE_ID_OFS;
  wire        in_uid    = (host_addr >= TCS_UNIQUE_ID_OFS) && (host_addr < TCS_IDENT_SIZE_OFS);
  wire        in_ident  = (host_addr >= TCS_IDENT_SIZE_OFS) && (host_addr < TCS_VOL_CTRL_OFS);

  // control byte as seen by each interface
  wire [7:0] ctl_host  = {wdone_ff, 5'h00, field_ff, harvest_on_ff};
  wire [7:0] ctl_radio = {1'b0, 5'h00, 1'b1, harvest_on_ff};
  wire       pw_match  = (pw_present_val == host_password_ff);
  wire       rcmd_ok   = radio_stb & field_ff;

  // host read mux; radio passwords read as zero
  always_comb
  begin
    nxt_host_rdata = 8'h00;
    if (hit_pw)
      nxt_host_rdata = tcs_byte_sel(host_password_ff, host_addr[1:0]);
    else if (hit_rpw)
      nxt_host_rdata = 8'h00;
    else if (hit_cfg)
      nxt_host_rdata = cfg_ff;
    else if (host_addr == TCS_REVISION_OFS)
      nxt_host_rdata = {REVISION, 4'h0};
    else if (host_addr == TCS_FAMILY_ID_OFS)
      nxt_host_rdata = TCS_FAMILY_RST;
    else if (host_addr == TCS_FORMAT_ID_OFS)
      nxt_host_rdata = TCS_FORMAT_RST;
    else if (in_uid)
      nxt_host_rdata = UNIQUE_ID[8*uid_off[2:0] +: 8];
    else if (in_ident)
      nxt_host_rdata = tcs_byte_sel(IDENT_SIZE, host_addr[1:0]);
    else if (hit_ctl)
      nxt_host_rdata = ctl_host;
  end

  // radio read mux
  always_comb
  begin
    nxt_radio_rdata = radio_rdata_ff;
    if (rcmd_ok && radio_cmd == TCS_RCMD_CFG_READ)
      nxt_radio_rdata = cfg_ff;
    else if (rcmd_ok && radio_cmd == TCS_RCMD_CTRL_READ)
      nxt_radio_rdata = ctl_radio;
  end

  // configuration byte: host writes all bits, radio writes masked fields
  always_comb
  begin
    nxt_cfg = cfg_ff;
    if (host_wr && hit_cfg)
      nxt_cfg = host_wdata;
    else if (rcmd_ok && radio_cmd == TCS_RCMD_HCFG_WRITE)
      nxt_cfg = {cfg_ff[7:3], radio_wdata[2:0]};
    else if (rcmd_ok && radio_cmd == TCS_RCMD_PCFG_WRITE)
      nxt_cfg[TCS_CFG_PIN_BIT] = radio_wdata[TCS_CFG_PIN_BIT];
  end

  // harvest enable: only bit 0 is writable, read-only bits are dropped
  always_comb
  begin
    nxt_harvest_on = harvest_on_ff;
    if (init_ff)
      nxt_harvest_on = ~cfg_ff[TCS_CFG_HDEF_BIT];
    else if (host_wr && hit_ctl)
      nxt_harvest_on = host_wdata[TCS_CTL_HON_BIT];
    else if (rcmd_ok && radio_cmd == TCS_RCMD_HON_WRITE)
      nxt_harvest_on = radio_wdata[TCS_CTL_HON_BIT];
  end

  // write-done flag: completion wins over a start in the same cycle
  assign nxt_wdone = nv_write_done_ok ? 1'b1 :
                     (nv_write_start ? 1'b0 : wdone_ff);

  // password unlock and rewrite; lock holds from power-on
  assign nxt_unlocked = (pw_present_stb && system_area_select) ? pw_match : unlocked_ff;
  assign nxt_host_password = (host_wr && hit_pw && unlocked_ff) ?
                             {host_addr[1:0] == 2'h3 ? host_wdata : host_password_ff[31:24],
                              host_addr[1:0] == 2'h2 ? host_wdata : host_password_ff[23:16],
                              host_addr[1:0] == 2'h1 ? host_wdata : host_password_ff[15:8],
                              host_addr[1:0] == 2'h0 ? host_wdata : host_password_ff[7:0]} :
                             host_password_ff;

  // configuration and passwords
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_ff           <= TCS_NV_CONFIG_RST;
      host_password_ff <= TCS_PASSWORD_RST;
      radio_pw_ff      <= {3{TCS_PASSWORD_RST}};
      unlocked_ff      <= 1'b0;
    end
    else if (clk_en)
    begin
      cfg_ff           <= nxt_cfg;
      host_password_ff <= nxt_host_password;
      unlocked_ff      <= nxt_unlocked;
    end
  end

  // control register state and read data
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      init_ff        <= 1'b1;
      harvest_on_ff  <= 1'b0;
      wdone_ff       <= 1'b0;
      field_ff       <= 1'b0;
      host_rdata_ff  <= 8'h00;
      radio_rdata_ff <= 8'h00;
      ack_ff         <= 1'b0;
    end
    else if (clk_en)
    begin
      init_ff        <= 1'b0;
      harvest_on_ff  <= nxt_harvest_on;
      wdone_ff       <= nxt_wdone;
      field_ff       <= field_power_ok;
      host_rdata_ff  <= host_acc ? nxt_host_rdata : host_rdata_ff;
      radio_rdata_ff <= nxt_radio_rdata;
      ack_ff         <= host_acc;
    end
  end

  // outputs; pin is open drain, pulled low only while indicating activity
  assign host_rdata            = host_rdata_ff;
  assign host_ack              = ack_ff;
  assign radio_rdata           = radio_rdata_ff;
  assign host_unlocked         = unlocked_ff;
  assign sink_range            = cfg_ff[TCS_CFG_SINK_HI_BIT:TCS_CFG_SINK_LO_BIT];
  assign harvest_out_en        = harvest_on_ff & harvest_conditions_ok;
  assign radio_activity_pin_o  = 1'b0;
  assign radio_activity_pin_oe = field_ff & (cfg_ff[TCS_CFG_PIN_BIT] ? radio_write_busy
                                                                     : radio_busy);

  // assertions
  a_harvest_gate: assert property (@(posedge clk) disable iff (!rstn)
    harvest_out_en |-> harvest_on_ff) else $error("harvest output without enable");
  a_radio_ctl_read: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && rcmd_ok && radio_cmd == TCS_RCMD_CTRL_READ) |=> (radio_rdata[7:1] == 7'h01))
    else $error("radio control read wrong");
  a_wdone_set: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && nv_write_done_ok) |=> wdone_ff) else $error("write done not set");
  a_wdone_clr: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && nv_write_start && !nv_write_done_ok) |=> !wdone_ff)
    else $error("write done not cleared");
  a_power_default: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && init_ff) |=> (harvest_on_ff == ~$past(cfg_ff[TCS_CFG_HDEF_BIT])))
    else $error("harvest default wrong");
  a_sink_follow: assert property (@(posedge clk) disable iff (!rstn)
    sink_range == cfg_ff[1:0]) else $error("sink range mismatch");
  a_pin_write_only: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && rcmd_ok && radio_cmd == TCS_RCMD_PCFG_WRITE && !(host_wr && hit_cfg))
    |=> (cfg_ff[2:0] == $past(cfg_ff[2:0]))) else $error("pin write touched harvest bits");
  a_field_track: assert property (@(posedge clk) disable iff (!rstn)
    clk_en |=> (field_ff == $past(field_power_ok))) else $error("field flag stale");
  a_pw_unlock: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && pw_present_stb && system_area_select && !pw_match) |=> !host_unlocked)
    else $error("unlock on mismatch");

  // named steps of the host and radio handshakes, shared by the properties below
  sequence s_host_take;
    clk_en && host_acc;
  endsequence

  sequence s_host_answer;
    host_ack;
  endsequence

  sequence s_radio_cfg_take;
    clk_en && rcmd_ok && (radio_cmd == TCS_RCMD_CFG_READ);
  endsequence

  sequence s_radio_ctl_take;
    clk_en && rcmd_ok && (radio_cmd == TCS_RCMD_CTRL_READ);
  endsequence

  sequence s_host_wr_cfg;
    clk_en && host_wr && hit_cfg;
  endsequence

  // host handshake: an accepted strobe is answered next cycle, a refused one never
  a_host_ack: assert property (@(posedge clk) disable iff (!rstn)
    s_host_take |=> s_host_answer) else $error("host access not acknowledged");
  a_no_ack: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !host_acc) |=> !host_ack) else $error("ack without accepted access");

  // read-only and hidden bytes: the host sees fixed values whatever it wrote before
  a_rpw_hidden: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && host_acc && hit_rpw) |=> (host_rdata == 8'h00))
    else $error("radio password visible to host");
  a_family_ro: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && host_acc && host_addr == TCS_FAMILY_ID_OFS) |=> (host_rdata == TCS_FAMILY_RST))
    else $error("family byte changed");
  a_format_ro: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && host_acc && host_addr == TCS_FORMAT_ID_OFS) |=> (host_rdata == TCS_FORMAT_RST))
    else $error("format byte changed");
  a_rev_low: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && host_acc && host_addr == TCS_REVISION_OFS) |=> (host_rdata[3:0] == 4'h0))
    else $error("reserved nibble not zero");
  a_ctl_zeros: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && host_acc && hit_ctl) |=> (host_rdata[6:2] == 5'h00))
    else $error("control reserved bits not zero");

  // configuration writes take effect on the very next edge, no second step needed
  a_cfg_host_wr: assert property (@(posedge clk) disable iff (!rstn)
    s_host_wr_cfg |=> (cfg_ff == $past(host_wdata)))
    else $error("host configuration write lost");
  a_hcfg_write: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && rcmd_ok && radio_cmd == TCS_RCMD_HCFG_WRITE && !(host_wr && hit_cfg))
    |=> (cfg_ff[2:0] == $past(radio_wdata[2:0]) && cfg_ff[7:3] == $past(cfg_ff[7:3])))
    else $error("radio harvest write wrong");
  a_radio_cfg: assert property (@(posedge clk) disable iff (!rstn)
    s_radio_cfg_take |=> (radio_rdata == $past(cfg_ff)))
    else $error("radio configuration read wrong");
  a_radio_hon: assert property (@(posedge clk) disable iff (!rstn)
    s_radio_ctl_take |=> (radio_rdata[0] == $past(harvest_on_ff)))
    else $error("radio control read lost enable");
  a_radio_ignored: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && radio_stb && !field_ff) |=> (radio_rdata == $past(radio_rdata)))
    else $error("radio command run without field");

  // control register: a write moves only the enable bit; the flag only moves on events
  a_ctl_ro_bits: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && host_wr && hit_ctl && !init_ff) |=> (harvest_on_ff == $past(host_wdata[0])))
    else $error("control write took wrong bit");
  a_wdone_hold: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !nv_write_start && !nv_write_done_ok) |=> (wdone_ff == $past(wdone_ff)))
    else $error("write done moved without event");

  // password: locked writes leave no trace, a full match opens and allows a rewrite
  a_pw_locked: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && host_wr && hit_pw && !unlocked_ff)
    |=> (host_password_ff == $past(host_password_ff)))
    else $error("password changed while locked");
  a_pw_match: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && pw_present_stb && system_area_select && pw_match) |=> host_unlocked)
    else $error("no unlock on match");
  a_unlock_hold: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !(pw_present_stb && system_area_select))
    |=> (host_unlocked == $past(host_unlocked)))
    else $error("unlock moved without presentation");
  a_pw_rewrite: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && host_wr && hit_pw && unlocked_ff && host_addr[1:0] == 2'h0)
    |=> (host_password_ff[7:0] == $past(host_wdata)))
    else $error("password rewrite lost");

  // outputs: harvesting opens with both conditions, pin is pulled only with the field
  a_harvest_open: assert property (@(posedge clk) disable iff (!rstn)
    (harvest_on_ff && harvest_conditions_ok) |-> harvest_out_en)
    else $error("harvest output held off");
  a_pin_released: assert property (@(posedge clk) disable iff (!rstn)
    !field_ff |-> !radio_activity_pin_oe) else $error("pin pulled without field");
  a_pin_busy: assert property (@(posedge clk) disable iff (!rstn)
    (field_ff && !cfg_ff[TCS_CFG_PIN_BIT]) |-> (radio_activity_pin_oe == radio_busy))
    else $error("busy mode pin wrong");
  a_pin_wip: assert property (@(posedge clk) disable iff (!rstn)
    (field_ff && cfg_ff[TCS_CFG_PIN_BIT]) |-> (radio_activity_pin_oe == radio_write_busy))
    else $error("write mode pin wrong");
  a_pin_low: assert property (@(posedge clk) disable iff (!rstn)
    radio_activity_pin_oe |-> !radio_activity_pin_o) else $error("pin driven high");

  // clock enable low freezes every register, the handshake included
  a_freeze: assert property (@(posedge clk) disable iff (!rstn)
    !clk_en |=> (cfg_ff == $past(cfg_ff) && host_ack == $past(host_ack)))
    else $error("state moved with enable low");

endmodule : tcs_system_area

// file: tcs_nv_model.sv
// far-side model: write-cycle engine that starts and completes non-volatile writes
`timescale 1ns/1ps
module tcs_nv_model
  import tcs_pkg::*;
#(
  parameter int WRITE_CYCLES = 6
)
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic go,
  output logic      nv_write_start,
  output logic      nv_write_done_ok
);
  logic [7:0] cnt_ff;
  logic       start_ff;
  logic       done_ff;
  // start pulse on request, done pulse after a fixed write time; short time keeps the run brief
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_ff   <= 8'h00;
      start_ff <= 1'b0;
      done_ff  <= 1'b0;
    end
    else
    begin
      start_ff <= go;
      done_ff  <= (cnt_ff == 8'h01);
      cnt_ff   <= go ? 8'(WRITE_CYCLES) : ((cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00);
    end
  end
  assign nv_write_start   = start_ff;
  assign nv_write_done_ok = done_ff;
endmodule : tcs_nv_model

// file: tcs_system_area_tb.sv
// testbench: host and radio access sequences against the system area
`timescale 1ns/1ps
module tcs_system_area_tb
  import tcs_pkg::*;
;
  logic clk, rstn, cen, stb, we, sel, pstb, go, rstb, rb, rwb, fok, hok;
  logic [15:0] addr;
  logic [7:0]  wd, rd, rrd, q;
  logic [31:0] pval;
  logic [2:0]  rcmd_v;
  logic [7:0]  rwd;
  logic        ack, unl, nst, ndn, pin_o, pin_oe, hen;
  logic [1:0]  sink;
  int          failures, compares;
  tcs_system_area dut_u (.clk(clk), .rstn(rstn), .clk_en(cen), .host_stb(stb), .host_we(we),
    .system_area_select(sel), .host_addr(addr), .host_wdata(wd), .host_rdata(rd),
    .host_ack(ack), .pw_present_stb(pstb), .pw_present_val(pval), .host_unlocked(unl),
    .nv_write_start(nst), .nv_write_done_ok(ndn), .radio_stb(rstb), .radio_cmd(rcmd_v),
    .radio_wdata(rwd), .radio_rdata(rrd), .radio_busy(rb), .radio_write_busy(rwb),
    .field_power_ok(fok), .harvest_conditions_ok(hok), .radio_activity_pin_o(pin_o),
    .radio_activity_pin_oe(pin_oe), .harvest_out_en(hen), .sink_range(sink));
  tcs_nv_model nv_u (.clk(clk), .rstn(rstn), .go(go), .nv_write_start(nst),
    .nv_write_done_ok(ndn));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // one host byte access; stb is a single-cycle pulse, ack awaited under a bound
  task hacc(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    we = w; addr = a; wd = d; stb = 1'b1; n = 0;
    do
    begin
      @(posedge clk); #2; stb = 1'b0; n++;
    end while (ack !== 1'b1 && n < 4);
    chk({7'h0, ack}, 8'h01);
    q = rd;
  endtask : hacc
  task rcmd(input logic [2:0] c, input logic [7:0] d);
    rcmd_v = c; rwd = d; rstb = 1'b1;
    @(posedge clk); #2; rstb = 1'b0;
    @(posedge clk); #2;
  endtask : rcmd
  task pw(input logic [31:0] v, input logic e);
    pval = v; pstb = 1'b1;
    @(posedge clk); #2; pstb = 1'b0;
    @(posedge clk); #2;
    chk({7'h0, unl}, {7'h0, e});
  endtask : pw
  task results;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  // watchdog well beyond the expected hundred-odd cycles
  initial
  begin
    #(5000 * 25);
    failures++;
    results;
  end
  initial
  begin
    failures = 0; compares = 0; rstn = 1'b0; stb = 0; we = 0; sel = 1; pstb = 0; go = 0;
    rstb = 0; rb = 0; rwb = 0; fok = 0; hok = 0; addr = 16'h0; wd = 8'h0; pval = 32'h0;
    rcmd_v = 3'h0; rwd = 8'h0; cen = 1;
    repeat (20) @(posedge clk);
    #2; rstn = 1'b1; fok = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    hacc(0, TCS_NV_CONFIG_OFS, 0); chk(q, 8'hF4);
    hacc(0, TCS_FAMILY_ID_OFS, 0); chk(q, 8'h00);
    hacc(0, TCS_FORMAT_ID_OFS, 0); chk(q, 8'hFF);
    hacc(0, TCS_HOST_PASSWORD_OFS, 0); chk(q, 8'h00);
    hacc(0, TCS_VOL_CTRL_OFS, 0); chk(q, 8'h02);
    hacc(0, TCS_REVISION_OFS, 0); chk(q & 8'hF0, 8'h10);
    hacc(0, TCS_UNIQUE_ID_OFS + 16'h7, 0); chk(q, 8'h01);
    hacc(0, TCS_IDENT_SIZE_OFS, 0); chk(q, 8'h33);
    hacc(1, TCS_FAMILY_ID_OFS, 8'h5A); hacc(0, TCS_FAMILY_ID_OFS, 0); chk(q, 8'h00);
    hacc(1, TCS_UNIQUE_ID_OFS, 8'h00); hacc(0, TCS_UNIQUE_ID_OFS, 0); chk(q, 8'hEF);
    for (int i = 1; i < 4; i++)
    begin
      hacc(1, TCS_HOST_PASSWORD_OFS + 16'(4 * i), 8'hA5);
      hacc(0, TCS_HOST_PASSWORD_OFS + 16'(4 * i), 0); chk(q, 8'h00);
    end
    for (int s = 0; s < 4; s++)
    begin
      hacc(1, TCS_NV_CONFIG_OFS, 8'(s)); hacc(0, TCS_NV_CONFIG_OFS, 0); chk(q, 8'(s));
      chk({6'h0, sink}, 8'(s));
    end
    // pin mode: busy indication, then write-in-progress indication
    hacc(1, TCS_NV_CONFIG_OFS, 8'h00); rb = 1; #1 chk({7'h0, pin_oe}, 8'h01);
    rb = 0; rwb = 1; #1 chk({7'h0, pin_oe}, 8'h00);
    hacc(1, TCS_NV_CONFIG_OFS, 8'h08); #1 chk({7'h0, pin_oe}, 8'h01);
    rb = 1; rwb = 0; #1 chk({6'h0, pin_o, pin_oe}, 8'h00);
    rb = 0; hok = 1;
    hacc(1, TCS_VOL_CTRL_OFS, 8'hFE); hacc(0, TCS_VOL_CTRL_OFS, 0); chk(q, 8'h02);
    chk({7'h0, hen}, 8'h00);
    hacc(1, TCS_VOL_CTRL_OFS, 8'h01); hacc(0, TCS_VOL_CTRL_OFS, 0); chk(q, 8'h03);
    chk({7'h0, hen}, 8'h01);
    hok = 0; #1 chk({7'h0, hen}, 8'h00);
    repeat (2)
    begin
      go = 1; @(posedge clk); #2; go = 0;
      @(posedge clk); #2; // start pulse must reach the flag before it is read
      hacc(0, TCS_VOL_CTRL_OFS, 0); chk(q, 8'h03);
      repeat (8) @(posedge clk);
      #2; hacc(0, TCS_VOL_CTRL_OFS, 0); chk(q, 8'h83);
    end
    rcmd(TCS_RCMD_CTRL_READ, 0); chk(rrd, 8'h03);
    rcmd(TCS_RCMD_HON_WRITE, 0); hacc(0, TCS_VOL_CTRL_OFS, 0); chk(q, 8'h82);
    rcmd(TCS_RCMD_CTRL_READ, 0); chk(rrd, 8'h02);
    rcmd(TCS_RCMD_HCFG_WRITE, 8'hF5); hacc(0, TCS_NV_CONFIG_OFS, 0); chk(q, 8'h0D);
    rcmd(TCS_RCMD_PCFG_WRITE, 8'h00); hacc(0, TCS_NV_CONFIG_OFS, 0); chk(q, 8'h05);
    rcmd(TCS_RCMD_CFG_READ, 0); chk(rrd, 8'h05);
    chk({6'h0, sink}, 8'h01);
    fok = 0; repeat (2) @(posedge clk);
    #2; rcmd(TCS_RCMD_HON_WRITE, 8'h01);
    hacc(0, TCS_VOL_CTRL_OFS, 0); chk(q, 8'h80);
    pw(32'h1, 0);
    hacc(1, TCS_HOST_PASSWORD_OFS, 8'h5A); hacc(0, TCS_HOST_PASSWORD_OFS, 0); chk(q, 8'h00);
    pw(32'h0, 1);
    hacc(1, TCS_HOST_PASSWORD_OFS, 8'h5A); hacc(0, TCS_HOST_PASSWORD_OFS, 0); chk(q, 8'h5A);
    pw(32'h0, 0);
    pw(32'h5A, 1);
    // clock enable low: a write leaves no trace and raises no ack
    cen = 0; we = 1; addr = TCS_NV_CONFIG_OFS; wd = 8'hAA; stb = 1;
    @(posedge clk); #2; stb = 0; we = 0; chk({7'h0, ack}, 8'h00);
    cen = 1; hacc(0, TCS_NV_CONFIG_OFS, 0); chk(q, 8'h05);
    // deselected area: strobe must be ignored
    sel = 0; stb = 1; @(posedge clk); #2; stb = 0;
    chk({7'h0, ack}, 8'h00);
    @(posedge clk); #2; chk({7'h0, ack}, 8'h00);
    sel = 1; rstn = 0; @(posedge clk); #2; rstn = 1; repeat (2) @(posedge clk);
    #2; hacc(0, TCS_VOL_CTRL_OFS, 0); chk(q, 8'h00);
    hacc(0, TCS_NV_CONFIG_OFS, 0); chk(q, 8'hF4);
    results;
  end
endmodule : tcs_system_area_tb
